// file: bench/rmmc_host_model.sv
// host model: mode pin drivers and the parameter reload responder
`timescale 1ns/100ps
`default_nettype none
module rmmc_host_model (
  // clock
  input wire logic ref_clk,
  // requests from the bench
  input wire logic [1:0] req_mode,
  input wire logic [3:0] reload_wait,
  // pins toward the device
  output logic mode_select_low,
  output logic mode_select_high,
  // reload engine handshake
  input wire logic reload_start,
  output logic reload_done
);
  int left = -1;

  // gpio writes land off the sampling edge, like a firmware port write;
  // one process drives both pins as a single driver, and reset covers time zero
  always @(negedge ref_clk) begin
    {mode_select_high, mode_select_low} <= req_mode;
  end

  // self-test engine: a wait of zero answers promptly, larger ones slowly
  always @(negedge ref_clk) begin
    reload_done <= (left == 0);
    if (reload_start) begin
      left <= int'(reload_wait);
    end else if (left >= 0) begin
      left <= left - 1;
    end
  end
endmodule : rmmc_host_model
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the mode controller and its host model
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module tb;
  import rmmc_pkg::*;
  // ------------------------------------------------------------
  // signals and counters
  // ------------------------------------------------------------
  localparam int SW = 20; // shortened idle switch delay
  localparam int HO = 40; // shortened holdoff after busy rises
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic tx_pending = 1'b0;
  logic rx_output_pending = 1'b0;
  logic ota_config_active = 1'b0;
  logic [1:0] req_mode = 2'h0;
  logic [3:0] reload_wait = 4'hc;
  logic mode_select_low, mode_select_high, reload_start, reload_done, busy_n;
  logic tx_en, rx_en, s2r_en, r2s_en, wake_en, cfg_en, sleep_en;
  rmmc_mode_type active_mode;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n;

  // ------------------------------------------------------------
  // design, host model, clock and watchdog
  // ------------------------------------------------------------
  rmmc_mode_ctrl #(.SWITCH_CYCLES(SW), .HOLDOFF_CYCLES(HO)) dut (
    .ref_clk(ref_clk), .reset(reset), .mode_select_low(mode_select_low),
    .mode_select_high(mode_select_high), .tx_pending(tx_pending),
    .rx_output_pending(rx_output_pending), .ota_config_active(ota_config_active),
    .reload_start(reload_start), .reload_done(reload_done), .active_mode(active_mode),
    .radio_tx_enable(tx_en), .radio_rx_enable(rx_en), .serial_to_radio_enable(s2r_en),
    .radio_to_serial_enable(r2s_en), .wake_preamble_enable(wake_en),
    .config_access_enable(cfg_en), .sleep_active(sleep_en), .busy_n(busy_n));
  rmmc_host_model host (
    .ref_clk(ref_clk), .req_mode(req_mode), .reload_wait(reload_wait),
    .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
    .reload_start(reload_start), .reload_done(reload_done));

  always #12.5 ref_clk = ~ref_clk;

  // the whole run needs about 1000 cycles, so this only cuts a hang
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      $display("MISMATCH t=%0t watchdog ran out", $time);
      close_out();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // bounded wait for busy high or for a given mode, cycles waited in n
  task automatic wait_for(input logic on_busy, input rmmc_mode_type m, input int lim);
    n = 0;
    while (n < lim && (on_busy ? busy_n !== 1'b1 : active_mode !== m)) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_for

  task automatic check_modes(input rmmc_mode_type m);
    logic run;
    run = (m == MODE_NORMAL) || (m == MODE_WOR);
    `CHK(active_mode, m, "mode")
    `CHK(s2r_en, run, "serial to radio")
    `CHK(r2s_en, run, "radio to serial")
    `CHK({tx_en, rx_en}, run ? 2'h3 : 2'h0, "radio enables")
    `CHK(wake_en, m == MODE_WOR, "wake code")
    `CHK(cfg_en, m == MODE_CONFIG, "config access")
    `CHK(sleep_en, m == MODE_SLEEP, "sleep")
  endtask : check_modes

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_boot();
    repeat (4) @(negedge ref_clk);
    `CHK(busy_n, 1'b0, "busy in reset")
    reset = 1'b0;
    wait_for(1'b1, MODE_NORMAL, 60);
    `CHK(n >= 12 && n < 60, 1'b1, "busy held through self-test")
    check_modes(MODE_NORMAL);
    reload_wait = 4'h1;
    $display("done: boot");
  endtask : t_boot

  // host waits out the holdoff, so the device is idle when pins move
  task automatic t_switch(input rmmc_mode_type m);
    logic was_sleep;
    was_sleep = (active_mode == MODE_SLEEP);
    repeat (HO + 5) @(negedge ref_clk);
    req_mode = m;
    wait_for(1'b0, m, SW + HO + 20);
    `CHK(n >= SW && n <= SW + 15, 1'b1, "idle switch time")
    if (was_sleep) begin
      `CHK(reload_start, 1'b1, "reload requested on wake")
      `CHK(busy_n, 1'b0, "busy during reload")
      wait_for(1'b1, m, 40);
      `CHK(busy_n, 1'b1, "busy after reload")
    end
    check_modes(m);
    $display("done: switch to mode %0d", m);
  endtask : t_switch

  task automatic t_pending(input logic use_rx, input rmmc_mode_type m);
    repeat (HO + 5) @(negedge ref_clk);
    tx_pending = !use_rx;
    rx_output_pending = use_rx;
    @(negedge ref_clk);
    `CHK(busy_n, 1'b0, "busy with work pending")
    req_mode = m;
    repeat (SW + HO + 20) @(negedge ref_clk);
    `CHK(active_mode, MODE_NORMAL, "switch held off")
    tx_pending = 1'b0;
    rx_output_pending = 1'b0;
    @(negedge ref_clk);
    `CHK(busy_n, 1'b1, "busy released")
    wait_for(1'b0, m, SW + HO + 20);
    `CHK(n >= HO - 1 && n <= HO + 5, 1'b1, "switch after drain")
    check_modes(m);
    $display("done: pending work then mode %0d", m);
  endtask : t_pending

  task automatic t_ota();
    ota_config_active = 1'b1;
    @(negedge ref_clk);
    `CHK({tx_en, rx_en}, 2'h3, "over-air config on")
    ota_config_active = 1'b0;
    @(negedge ref_clk);
    `CHK({tx_en, rx_en}, 2'h0, "over-air config off")
    $display("done: over-air config");
  endtask : t_ota

  task automatic t_glitch();
    repeat (HO + 5) @(negedge ref_clk);
    req_mode = 2'h3;
    repeat (2) @(negedge ref_clk);
    req_mode = 2'h0;
    repeat (SW + 20) @(negedge ref_clk);
    `CHK(active_mode, MODE_NORMAL, "glitch ignored")
    // the pair never rests on the current mode, so only the filter holds it off
    repeat (12) begin
      req_mode = 2'h1;
      repeat (3) @(negedge ref_clk);
      req_mode = 2'h2;
      repeat (3) @(negedge ref_clk);
    end
    `CHK(active_mode, MODE_NORMAL, "chattering pins ignored")
    req_mode = 2'h0;
    repeat (10) @(negedge ref_clk);
    `CHK(active_mode, MODE_NORMAL, "mode kept after chatter")
    $display("done: pin glitch");
  endtask : t_glitch

  initial begin
    t_boot();
    t_switch(MODE_WOR);
    t_switch(MODE_CONFIG);
    t_ota();
    t_switch(MODE_SLEEP);
    t_switch(MODE_NORMAL);
    t_pending(1'b0, MODE_CONFIG);
    t_switch(MODE_NORMAL);
    t_pending(1'b1, MODE_SLEEP);
    t_switch(MODE_NORMAL);
    t_glitch();
    close_out();
  end
endmodule : tb
`default_nettype wire

// file: include/rmmc_pkg.sv
// constants and types shared by the radio module mode control block
`default_nettype none
package rmmc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;          // 40 mhz reference clock
  localparam int SWITCH_DELAY_NS = 1_000_000; // idle mode switch, 1 ms
  localparam int HOLDOFF_NS = 2_000_000;      // after busy rises, 2 ms
  // longest time: round down
  localparam int SWITCH_CYC = SWITCH_DELAY_NS / CLK_PERIOD_NS;
  // least time: round up
  localparam int HOLDOFF_CYC = (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 18;                  // holds both counts above
  localparam int STABLE_CYC = 4;              // pin pair must hold one cycle longer than this
  localparam int FILT_CNT_W = 3;

  // ----------------------------------------------------------------
  // mode encoding: {mode_select_high, mode_select_low}
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_WOR    = 2'h1,
    MODE_CONFIG = 2'h2,
    MODE_SLEEP  = 2'h3
  } rmmc_mode_type;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_BOOT_START = 2'b00,
    ST_BOOT_WAIT  = 2'b01,
    ST_RELOAD     = 2'b10,
    ST_RUN        = 2'b11
  } rmmc_state_type;

  localparam rmmc_mode_type MODE_RESET = MODE_NORMAL;
  localparam logic [1:0] PINS_RESET = 2'h0;

endpackage : rmmc_pkg
`default_nettype wire

// file: verilog/rmmc_mode_ctrl.sv
// operating mode controller with busy indicator for the radio module
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - both pins low: mode 0, serial sent over radio
// - mode 0: receiver on, payloads forwarded to serial
// - mode 1: wake-up code before each transmission
// - mode 1 receives exactly like mode 0
// - mode 2: radio off except over-air configuration
// - mode 2: host accesses configuration registers serially
// - both pins high: deep sleep, no radio
// - leaving sleep reloads parameters, busy held low
// - idle device switches mode after 1 ms
// - pending radio transmit finishes before switching
// - pending serial output finishes before switching
// - mode change only while busy is high
// - streaming host: selection ignored until data drained
// - pending work done, then switch within 1 ms; code also waits the 2 ms holdoff after busy rises
// - busy low whenever any busy condition holds
// - no detection while busy; entry 2 ms after rise
module rmmc_mode_ctrl #(
  parameter int SWITCH_CYCLES = rmmc_pkg::SWITCH_CYC,
  parameter int HOLDOFF_CYCLES = rmmc_pkg::HOLDOFF_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // mode-select pins from the host
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  // data path status
  input wire logic tx_pending,
  input wire logic rx_output_pending,
  input wire logic ota_config_active,
  // parameter reload handshake
  output logic reload_start,
  input wire logic reload_done,
  // mode and enables
  output rmmc_pkg::rmmc_mode_type active_mode,
  output logic radio_tx_enable,
  output logic radio_rx_enable,
  output logic serial_to_radio_enable,
  output logic radio_to_serial_enable,
  output logic wake_preamble_enable,
  output logic config_access_enable,
  output logic sleep_active,
  // busy indicator pin, low while busy
  output logic busy_n
);
  import rmmc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rmmc_state_type st;
    rmmc_mode_type mode;
    logic busy_n;
    logic reload_go;
    logic [CNT_W-1:0] settle;
    logic [CNT_W-1:0] age;
  } rmmc_ctrl_type;

  localparam logic [CNT_W-1:0] SWITCH_LIM = CNT_W'(SWITCH_CYCLES);
  localparam logic [CNT_W-1:0] HOLD_LIM = CNT_W'(HOLDOFF_CYCLES);

  rmmc_ctrl_type ctl_q;
  rmmc_ctrl_type ctl_d;
  logic [1:0] pins_stable;
  rmmc_mode_type req_mode;
  logic work_pending;
  logic switch_ok;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  rmmc_pin_filter #(
    .STABLE(STABLE_CYC)
  ) u_pin_filter (
    .ref_clk(ref_clk),
    .reset(reset),
    .pins_async({mode_select_high, mode_select_low}),
    .pins_stable(pins_stable)
  );

  assign req_mode = rmmc_mode_type'(pins_stable);
  // host streaming keeps tx_pending up, which holds the switch off
  assign work_pending = tx_pending | rx_output_pending;
  // both the idle delay and the post-busy holdoff must have run out
  assign switch_ok = (ctl_q.settle >= SWITCH_LIM) && (ctl_q.age >= HOLD_LIM);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    ctl_d = ctl_q;
    ctl_d.reload_go = 1'b0;
    case (ctl_q.st)
      ST_BOOT_START: begin
        // self-test and parameter load right after reset
        ctl_d.reload_go = 1'b1;
        ctl_d.st = ST_BOOT_WAIT;
      end
      ST_BOOT_WAIT: begin
        if (reload_done) begin
          ctl_d.mode = req_mode; // start in the mode the pins select
          ctl_d.st = ST_RUN;
        end
      end
      ST_RELOAD: begin
        if (reload_done) begin
          ctl_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (switch_ok && req_mode != ctl_q.mode) begin
          ctl_d.mode = req_mode;
          if (ctl_q.mode == MODE_SLEEP) begin
            ctl_d.reload_go = 1'b1;
            ctl_d.st = ST_RELOAD;
          end
        end
      end
      default: ctl_d.st = ST_BOOT_START;
    endcase
    // busy while reloading or any traffic is still pending
    ctl_d.busy_n = (ctl_d.st == ST_RUN) && !work_pending;
    // time since busy went high, saturating
    if (!ctl_q.busy_n) begin
      ctl_d.age = '0;
    end else if (ctl_q.age != HOLD_LIM) begin
      ctl_d.age = ctl_q.age + CNT_W'(1);
    end
    // time a differing request has been waiting with the block idle;
    // detection is frozen while busy, so the count restarts
    if (!ctl_q.busy_n || work_pending || req_mode == ctl_q.mode ||
        ctl_d.mode != ctl_q.mode) begin
      ctl_d.settle = '0;
    end else if (ctl_q.settle != SWITCH_LIM) begin
      ctl_d.settle = ctl_q.settle + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl_q <= '{st: ST_BOOT_START, mode: MODE_RESET, busy_n: 1'b0,
                 reload_go: 1'b0, settle: '0, age: '0};
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic run;
  logic transparent;
  assign run = ctl_q.st == ST_RUN;
  // modes 0 and 1 share the transparent data path
  assign transparent = run && (ctl_q.mode == MODE_NORMAL || ctl_q.mode == MODE_WOR);
  assign active_mode = ctl_q.mode;
  assign reload_start = ctl_q.reload_go;
  assign busy_n = ctl_q.busy_n;
  // config mode turns the radio on only for over-air configuration
  assign radio_tx_enable = transparent ||
                           (run && ctl_q.mode == MODE_CONFIG && ota_config_active);
  assign radio_rx_enable = radio_tx_enable;
  assign serial_to_radio_enable = transparent;
  assign radio_to_serial_enable = transparent;
  assign wake_preamble_enable = run && ctl_q.mode == MODE_WOR;
  assign config_access_enable = run && ctl_q.mode == MODE_CONFIG;
  assign sleep_active = run && ctl_q.mode == MODE_SLEEP;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence seq_leave_sleep;
    ctl_q.st == ST_RUN && ctl_q.mode == MODE_SLEEP && ctl_d.mode != MODE_SLEEP;
  endsequence

  sequence seq_reloading;
    ctl_q.st == ST_RELOAD && !busy_n && reload_start;
  endsequence

  a_sleep_reload: assert property (@(posedge ref_clk) disable iff (reset)
    seq_leave_sleep |=> seq_reloading)
    else $error("leaving sleep did not start a reload with busy low");

  a_reload_busy: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl_q.st == ST_RELOAD && !reload_done) |=> !busy_n)
    else $error("busy rose before reload completed");

  a_busy_pending: assert property (@(posedge ref_clk) disable iff (reset)
    (tx_pending || rx_output_pending) |=> !busy_n)
    else $error("busy high while work pending");

  a_busy_idle: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl_q.st == ST_RUN && ctl_d.st == ST_RUN && !work_pending) |=> busy_n)
    else $error("busy low with no busy condition");

  a_no_switch_busy: assert property (@(posedge ref_clk) disable iff (reset)
    !busy_n |=> $stable(active_mode) || $past(ctl_q.st) == ST_BOOT_WAIT)
    else $error("mode changed while busy");

  a_switch_delays: assert property (@(posedge ref_clk) disable iff (reset)
    ($past(ctl_q.st) == ST_RUN && $changed(active_mode)) |->
      ($past(ctl_q.age) >= HOLD_LIM && $past(ctl_q.settle) >= SWITCH_LIM))
    else $error("mode switched before holdoff or idle delay");

  a_idle_switch: assert property (@(posedge ref_clk) disable iff (reset)
    (run && ctl_q.busy_n && !work_pending && switch_ok &&
     req_mode != ctl_q.mode) |=> active_mode == $past(req_mode))
    else $error("idle device did not switch after delay");

  a_mode0_paths: assert property (@(posedge ref_clk) disable iff (reset)
    (run && active_mode == MODE_NORMAL) |->
      (serial_to_radio_enable && radio_to_serial_enable && radio_rx_enable))
    else $error("mode 0 data paths not enabled");

  a_wor_preamble: assert property (@(posedge ref_clk) disable iff (reset)
    (run && active_mode == MODE_WOR) |->
      (wake_preamble_enable && radio_to_serial_enable && radio_tx_enable))
    else $error("mode 1 lacks preamble or receive path");

  a_config_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    (active_mode == MODE_CONFIG && !ota_config_active) |->
      (!radio_tx_enable && !radio_rx_enable && !serial_to_radio_enable))
    else $error("radio on in config mode without over-air config");

  a_sleep_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    (active_mode == MODE_SLEEP) |-> (!radio_tx_enable && !radio_rx_enable))
    else $error("radio active in deep sleep");

endmodule : rmmc_mode_ctrl
`default_nettype wire

// file: verilog/rmmc_pin_filter.sv
// two-flop synchroniser and stability filter for the mode-select pins
`timescale 1ns/100ps
`default_nettype none
module rmmc_pin_filter #(
  parameter int STABLE = rmmc_pkg::STABLE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // asynchronous pins
  input wire logic [1:0] pins_async,
  // filtered pair
  output logic [1:0] pins_stable
);
  import rmmc_pkg::*;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] last;
    logic [1:0] stable;
    logic [FILT_CNT_W-1:0] cnt;
  } rmmc_filt_type;

  localparam logic [FILT_CNT_W-1:0] CNT_LIM = FILT_CNT_W'(STABLE - 1);

  rmmc_filt_type filt_q;
  rmmc_filt_type filt_d;

  // sync1 is read only by sync2; the filter looks at sync2 onward
  always_comb begin
    filt_d = filt_q;
    filt_d.sync1 = pins_async;
    filt_d.sync2 = filt_q.sync1;
    if (filt_q.sync2 != filt_q.last) begin
      filt_d.last = filt_q.sync2;
      filt_d.cnt = '0;
    end else if (filt_q.cnt != CNT_LIM) begin
      filt_d.cnt = filt_q.cnt + FILT_CNT_W'(1);
    end else begin
      filt_d.stable = filt_q.last; // a glitch never reaches here
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      filt_q <= '{sync1: PINS_RESET, sync2: PINS_RESET, last: PINS_RESET,
                  stable: PINS_RESET, cnt: '0};
    end else begin
      filt_q <= filt_d;
    end
  end

  assign pins_stable = filt_q.stable;

  // output only moves after the pair held still for the full count
  a_filter_stable: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(pins_stable) |-> $past(filt_q.cnt) == CNT_LIM)
    else $error("filtered mode pins changed before settling");

endmodule : rmmc_pin_filter
`default_nettype wire
